// ===== include/pss_defines.vh
// Constants for the profiling state save image: offsets, field positions and sizes.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH
`define PSS_FEATURE_BIT        62
`define PSS_IMAGE_BYTES        128
`define PSS_AREA_OFFSET        13'h340
`define PSS_WORDS              16
`define PSS_WORD_IDX_W         4
`define PSS_NUM_EVENTS         6
`define PSS_FLAG_FIRST         1
`define PSS_RING_SIZE_W        28
`define PSS_W_CB_ADDR          4'h0
`define PSS_W_FLAGS_HEAD       4'h1
`define PSS_W_RING_BASE        4'h2
`define PSS_W_SIZE_FILTER      4'h3
`define PSS_W_PENDING_FIRST    4'h4
`define PSS_W_PENDING_LAST     4'h7
`define PSS_W_COUNT_12         4'h8
`define PSS_W_COUNT_34         4'h9
`define PSS_W_COUNT_56         4'ha
`define PSS_PENDING_ID_W       8
`endif

// ===== logic/pss_save_area.v
// Profiling state holder with save-image emitter and restore loader.
// Behaviour
// - Bit 62 of the feature enable register gates save and restore of profiling state.
// - Image is 128 bytes at offset 832 of the save area.
// - Bytes 7-0 hold control block address; zero means profiling disabled.
// - Flag bit 1 marks event 1 active; restore loads counter from slot one.
// - Flag bits 6:2 serve events 2-6; bit 0, 15:7 and next bytes reserved.
// - Head offset bytes 15-12, base 23-16, size bits 27:0 of next word.
// - Bytes 31-28 hold filter settings as in the control block.
// - Bytes 63-32 hold pending record; zero identifier means none pending.
// - Counters 1-6 in bytes 64-87, valid per flag; 127-88 reserved.
// - All reserved fields and bits in the image are zero.
// - Disabled save stores nothing and clears header bitmap bit 62.
// - Enabled save copies state, storing zero for counters whose flag is clear, and sets header bitmap bit 62.
// - Restore with bitmap bit clear loads defaults, disabling profiling.
`timescale 1ns/100ps
`include "pss_defines.vh"
module pss_save_area (
  input  wire         clk,
  input  wire         rst,
  input  wire [63:0]  extended_feature_enable_reg,
  input  wire         save_req,
  input  wire         save_feature_sel,
  input  wire         restore_req,
  input  wire         restore_feature_sel,
  input  wire [63:0]  restore_bitmap,
  input  wire         restore_word_valid,
  input  wire [63:0]  restore_word,
  input  wire         live_load,
  input  wire [63:0]  live_cb_addr,
  input  wire [31:0]  live_head,
  input  wire [63:0]  live_base,
  input  wire [27:0]  live_size,
  input  wire [31:0]  live_filter,
  input  wire [255:0] live_pending,
  input  wire [6:0]   live_flags,
  input  wire [191:0] live_counts,
  output reg          image_valid,
  output reg  [12:0]  image_addr,
  output reg  [63:0]  image_data,
  output reg          bitmap_write,
  output reg          bitmap_bit,
  output reg          busy,
  output reg          done,
  output reg          profiling_offered,
  output reg          profiling_enabled,
  output reg  [63:0]  active_control_block_addr,
  output reg  [6:0]   counter_active_flags,
  output reg  [31:0]  ring_head_offset,
  output reg  [63:0]  ring_base_addr,
  output reg  [27:0]  ring_size,
  output reg  [31:0]  filter_bits,
  output reg  [255:0] pending_event_image,
  output reg          pending_valid,
  output reg  [191:0] event_counts
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SAVE = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  idx;
  wire [63:0] mux_word;
  wire        offered = extended_feature_enable_reg[`PSS_FEATURE_BIT];
  wire        enabled = (active_control_block_addr != 64'h0);

  pss_word_mux u_mux (
    .idx     (idx),
    .cb_addr (active_control_block_addr),
    .flags   (counter_active_flags),
    .head    (ring_head_offset),
    .base    (ring_base_addr),
    .size    (ring_size),
    .filt    (filter_bits),
    .pend    (pending_event_image),
    .cnt     (event_counts),
    .word    (mux_word)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      idx <= 4'h0;
      image_valid <= 1'b0;
      image_addr <= 13'h0000;
      image_data <= 64'h0;
      bitmap_write <= 1'b0;
      bitmap_bit <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      profiling_offered <= 1'b0;
      profiling_enabled <= 1'b0;
      active_control_block_addr <= 64'h0;
      counter_active_flags <= 7'h00;
      ring_head_offset <= 32'h0;
      ring_base_addr <= 64'h0;
      ring_size <= 28'h0;
      filter_bits <= 32'h0;
      pending_event_image <= 256'h0;
      pending_valid <= 1'b0;
      event_counts <= 192'h0;
    end else begin
      image_valid <= 1'b0;
      bitmap_write <= 1'b0;
      done <= 1'b0;
      profiling_offered <= offered;
      profiling_enabled <= enabled;
      pending_valid <= (pending_event_image[`PSS_PENDING_ID_W-1:0] != 8'h00);
      case (state)
        ST_IDLE: begin
          if (live_load) begin
            active_control_block_addr <= live_cb_addr;
            counter_active_flags <= {live_flags[6:1], 1'b0};
            ring_head_offset <= live_head;
            ring_base_addr <= live_base;
            ring_size <= live_size;
            filter_bits <= live_filter;
            pending_event_image <= live_pending;
            event_counts <= live_counts;
          end else if (save_req && offered && save_feature_sel) begin
            bitmap_write <= 1'b1;
            bitmap_bit <= enabled;
            busy <= 1'b1;
            idx <= 4'h0;
            if (enabled) begin
              state <= ST_SAVE;
            end else begin
              state <= ST_DONE;
            end
          end else if (restore_req && offered && restore_feature_sel) begin
            busy <= 1'b1;
            idx <= 4'h0;
            if (restore_bitmap[`PSS_FEATURE_BIT]) begin
              state <= ST_LOAD;
            end else begin
              // Defaults: address zero disables profiling, other state is cleared.
              active_control_block_addr <= 64'h0;
              counter_active_flags <= 7'h00;
              ring_head_offset <= 32'h0;
              ring_base_addr <= 64'h0;
              ring_size <= 28'h0;
              filter_bits <= 32'h0;
              pending_event_image <= 256'h0;
              event_counts <= 192'h0;
              state <= ST_DONE;
            end
          end
        end
        ST_SAVE: begin
          image_valid <= 1'b1;
          image_data <= mux_word;
          image_addr <= `PSS_AREA_OFFSET + {6'h00, idx, 3'h0};
          idx <= idx + 4'h1;
          if (idx == 4'hf) begin
            state <= ST_DONE;
          end
        end
        ST_LOAD: begin
          if (restore_word_valid) begin
            case (idx)
              `PSS_W_CB_ADDR:     active_control_block_addr <= restore_word;
              `PSS_W_FLAGS_HEAD: begin
                counter_active_flags <= {restore_word[6:1], 1'b0};
                ring_head_offset <= restore_word[63:32];
              end
              `PSS_W_RING_BASE:   ring_base_addr <= restore_word;
              `PSS_W_SIZE_FILTER: begin
                ring_size <= restore_word[27:0];
                filter_bits <= restore_word[63:32];
              end
              4'h4:               pending_event_image[63:0] <= restore_word;
              4'h5:               pending_event_image[127:64] <= restore_word;
              4'h6:               pending_event_image[191:128] <= restore_word;
              4'h7:               pending_event_image[255:192] <= restore_word;
              `PSS_W_COUNT_12:    event_counts[63:0] <= restore_word;
              `PSS_W_COUNT_34:    event_counts[127:64] <= restore_word;
              `PSS_W_COUNT_56:    event_counts[191:128] <= restore_word;
              default:            idx <= idx;
            endcase
            idx <= idx + 4'h1;
            if (idx == 4'hf) begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // A zero address clears the counter active flags loaded with it.
          if (active_control_block_addr == 64'h0) begin
            counter_active_flags <= 7'h00;
          end
          busy <= 1'b0;
          done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // pss_save_area

// ===== logic/pss_word_mux.v
// Selects one 64-bit word of the profiling save image by index.
`timescale 1ns/100ps
`include "pss_defines.vh"
module pss_word_mux (
  input  wire [3:0]   idx,
  input  wire [63:0]  cb_addr,
  input  wire [6:0]   flags,
  input  wire [31:0]  head,
  input  wire [63:0]  base,
  input  wire [27:0]  size,
  input  wire [31:0]  filt,
  input  wire [255:0] pend,
  input  wire [191:0] cnt,
  output reg  [63:0]  word
);
  wire [5:0] cmask;
  wire [191:0] cgated;
  genvar g;
  // Counters are stored only when their flag is set; others stay zero.
  generate
    for (g = 0; g < `PSS_NUM_EVENTS; g = g + 1) begin : gc
      assign cmask[g] = flags[g + `PSS_FLAG_FIRST];
      assign cgated[g*32 +: 32] = cmask[g] ? cnt[g*32 +: 32] : 32'h0000_0000;
    end
  endgenerate

  always @* begin
    case (idx)
      `PSS_W_CB_ADDR:     word = cb_addr;
      `PSS_W_FLAGS_HEAD:  word = {head, 16'h0000, 9'h000, flags[6:1], 1'b0};
      `PSS_W_RING_BASE:   word = base;
      `PSS_W_SIZE_FILTER: word = {filt, 4'h0, size};
      4'h4:               word = pend[63:0];
      4'h5:               word = pend[127:64];
      4'h6:               word = pend[191:128];
      `PSS_W_PENDING_LAST: word = pend[255:192];
      `PSS_W_COUNT_12:    word = cgated[63:0];
      `PSS_W_COUNT_34:    word = cgated[127:64];
      `PSS_W_COUNT_56:    word = cgated[191:128];
      default:            word = 64'h0;
    endcase
  end
endmodule // pss_word_mux

// ===== tb/pss_mem_model.sv
// Save area memory that records the image and header bitmap and replays them.
`timescale 1ns/100ps
module pss_mem_model (
  input  wire        clk,
  input  wire        image_valid,
  input  wire [12:0] image_addr,
  input  wire [63:0] image_data,
  input  wire        bitmap_write,
  input  wire        bitmap_bit,
  input  wire        gap,
  input  wire        play,
  output reg         word_valid,
  output reg  [63:0] word,
  output reg  [63:0] bitmap
);
  reg [63:0] mem [0:15];
  reg [4:0]  idx = 5'h10;
  reg        slow = 1'b0;
  initial begin
    word_valid = 1'b0;
    word = 64'h0;
    bitmap = 64'h0;
  end
  always @(posedge clk) begin
    if (image_valid) mem[image_addr[6:3] ^ 4'h8] <= image_data;
    if (bitmap_write) bitmap[62] <= bitmap_bit;
    word_valid <= 1'b0;
    word <= ~word;
    if (play) idx <= 5'h00;
    else if (!idx[4]) begin
      slow <= ~slow;
      if (!gap || slow) begin
        word_valid <= 1'b1;
        word <= mem[idx[3:0]];
        idx <= idx + 5'h01;
      end
    end
  end
endmodule // pss_mem_model

// ===== tb/pss_props.sv
// Port checks for the profiling save area.
`timescale 1ns/100ps
module pss_props (
  input wire        clk,
  input wire        rst,
  input wire [63:0] extended_feature_enable_reg,
  input wire        save_req,
  input wire        save_feature_sel,
  input wire        restore_req,
  input wire        restore_feature_sel,
  input wire [63:0] restore_bitmap,
  input wire        live_load,
  input wire        image_valid,
  input wire [12:0] image_addr,
  input wire [63:0] image_data,
  input wire        bitmap_write,
  input wire        bitmap_bit,
  input wire        busy,
  input wire        done,
  input wire [63:0] active_control_block_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire go = !busy && !live_load && extended_feature_enable_reg[62];
  chk_save_bitmap: assert property (go && save_req && save_feature_sel |=> bitmap_write
    && bitmap_bit == ($past(active_control_block_addr) != 64'h0)) else $error("bad bitmap");
  chk_ignore_req: assert property (!busy && !extended_feature_enable_reg[62] |=> !busy)
    else $error("request taken with feature off");
  chk_image_addr: assert property (image_valid |-> image_addr[2:0] == 3'h0
    && image_addr >= 13'h340 && image_addr <= 13'h3b8) else $error("bad image address");
  chk_word_order: assert property (image_valid && image_addr != 13'h3b8 |=> image_valid
    && image_addr == $past(image_addr) + 13'h8) else $error("words out of order");
  chk_first_word: assert property (image_valid && image_addr == 13'h340 |->
    image_data == active_control_block_addr) else $error("bad address word");
  chk_rsvd_zero: assert property (image_valid && image_addr >= 13'h398 |->
    image_data == 64'h0) else $error("reserved word not zero");
  chk_off_path: assert property (bitmap_write && !bitmap_bit |=> done && !image_valid)
    else $error("disabled save wrong");
  chk_on_path: assert property (bitmap_write && bitmap_bit |=> image_valid ##16 done)
    else $error("enabled save wrong");
  chk_default_load: assert property (go && restore_req && restore_feature_sel && !save_req
    && !restore_bitmap[62] |=> active_control_block_addr == 64'h0 ##1 done)
    else $error("default restore wrong");
endmodule // pss_props
bind pss_save_area pss_props u_props (
  .clk                         (clk),
  .rst                         (rst),
  .extended_feature_enable_reg (extended_feature_enable_reg),
  .save_req                    (save_req),
  .save_feature_sel            (save_feature_sel),
  .restore_req                 (restore_req),
  .restore_feature_sel         (restore_feature_sel),
  .restore_bitmap              (restore_bitmap),
  .live_load                   (live_load),
  .image_valid                 (image_valid),
  .image_addr                  (image_addr),
  .image_data                  (image_data),
  .bitmap_write                (bitmap_write),
  .bitmap_bit                  (bitmap_bit),
  .busy                        (busy),
  .done                        (done),
  .active_control_block_addr   (active_control_block_addr)
);

// ===== tb/tb_pss_save_area.sv
// Self-checking bench for the profiling save area.
`timescale 1ns/100ps
module tb_pss_save_area;
  reg          clk, rst, sv, ssel, rs, rsel, ld, gap, play, x;
  reg  [63:0]  fer, cb, bs;
  reg  [31:0]  hd, ft, seed;
  reg  [27:0]  sz;
  reg  [255:0] pd;
  reg  [6:0]   fl;
  reg  [191:0] ct;
  wire         iv, bw, bb, busy, done, off, pv, wv, q_en;
  wire [191:0] q_ct;
  wire [12:0]  ia;
  wire [63:0]  id, w, bm, q_cb, q_bs;
  wire [6:0]   q_fl;
  wire [31:0]  q_hd, q_ft;
  wire [27:0]  q_sz;
  wire [255:0] q_pd;
  integer      fails, compares, k, n;
  pss_save_area DUT (.clk(clk), .rst(rst), .extended_feature_enable_reg(fer),
    .save_req(sv), .save_feature_sel(ssel), .restore_req(rs), .restore_feature_sel(rsel),
    .restore_bitmap(bm), .restore_word_valid(wv), .restore_word(w), .live_load(ld),
    .live_cb_addr(cb ^ {64{x}}), .live_head(hd ^ {32{x}}), .live_base(bs ^ {64{x}}),
    .live_size(sz ^ {28{x}}), .live_filter(ft ^ {32{x}}), .live_pending(pd ^ {256{x}}),
    .live_flags(fl ^ {7{x}}), .live_counts(ct), .image_valid(iv), .image_addr(ia),
    .image_data(id), .bitmap_write(bw), .bitmap_bit(bb), .busy(busy), .done(done),
    .profiling_offered(off), .profiling_enabled(q_en), .active_control_block_addr(q_cb),
    .counter_active_flags(q_fl), .ring_head_offset(q_hd), .ring_base_addr(q_bs),
    .ring_size(q_sz), .filter_bits(q_ft), .pending_event_image(q_pd),
    .pending_valid(pv), .event_counts(q_ct));
  pss_mem_model m (.clk(clk), .image_valid(iv), .image_addr(ia), .image_data(id),
    .bitmap_write(bw), .bitmap_bit(bb), .gap(gap), .play(play), .word_valid(wv),
    .word(w), .bitmap(bm));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function [31:0] rnd(input d); begin
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed;
  end endfunction
  function [63:0] exp_word(input [3:0] i); begin
    case (i)
      0: exp_word = cb;
      1: exp_word = {hd, 16'h0, 9'h0, fl[6:1], 1'b0};
      2: exp_word = bs;
      3: exp_word = {ft, 4'h0, sz};
      4, 5, 6, 7: exp_word = pd[(i - 4) * 64 +: 64];
      8, 9, 10: exp_word = {fl[2 * i - 14] ? ct[(2 * i - 15) * 32 +: 32] : 32'h0,
        fl[2 * i - 15] ? ct[(2 * i - 16) * 32 +: 32] : 32'h0};
      default: exp_word = 64'h0;
    endcase
  end endfunction
  task chk(input [255:0] seen, input [255:0] exp, input [63:0] name); begin
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch %0s exp %h seen %h", name, exp, seen);
    end
  end endtask
  task finish_test; begin
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  end endtask
  task load(input i); begin
    @(negedge clk);
    {x, ld} = {i, 1'b1};
    @(negedge clk);
    {x, ld} = 2'b00;
  end endtask
  task op(input s, input r); begin
    @(negedge clk);
    {sv, rs, play} = {s, r, r & bm[62]};
    @(negedge clk);
    {sv, rs, play} = 3'b000;
    // Only a request that is offered and selected is answered with done.
    if (fer[62] && (s ? ssel : rsel)) begin
      for (n = 0; n < 45 && !done; n = n + 1) @(posedge clk) #1;
      if (!done) begin
        fails = fails + 1;
        finish_test;
      end
    end
  end endtask
  initial begin
    {fails, compares, k, n} = 0;
    {sv, ssel, rs, rsel, ld, gap, play, x, fer, cb, bs, hd, ft, sz, pd, fl, ct} = 0;
    seed = 32'h0be93f6d;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk) {rst, ssel, rsel} = 3'b011;
    op(1'b1, 1'b0) ;
    chk({busy, bw, off}, 3'b000, "refuse");
    {fer[62], ssel} = 2'b10;
    op(1'b1, 1'b0);
    chk({busy, bw}, 2'b00, "nosel");
    ssel = 1'b1;
    for (k = 0; k < 3; k = k + 1) begin
      cb = k == 2 ? 64'h0 : {rnd(0), rnd(0)};
      {hd, ft, sz, fl, bs} = {rnd(0), rnd(0), rnd(0), rnd(0), rnd(0), rnd(0)};
      ct = {rnd(0), rnd(0), rnd(0), rnd(0), rnd(0), rnd(0)};
      pd = {8{rnd(0)}} & {248'h0 - 1'b1, {8{k != 1}}};
      gap = k[0];
      load(1'b0);
      chk(off, 1'b1, "offered");
      op(1'b1, 1'b0);
      chk(bm[62], cb != 0, "bitmap");
      for (n = 0; n < 16 && cb != 0; n = n + 1) chk(m.mem[n], exp_word(n[3:0]), "word");
      load(1'b1);
      op(1'b0, 1'b1);
      chk(q_cb, cb, "cbaddr");
      chk(q_fl, fl & 7'h7e & {7{cb != 0}}, "flags");
      chk({q_hd, q_bs, q_sz, q_ft}, {hd, bs, sz, ft} & {156{cb != 0}}, "ring");
      chk({pv, q_pd}, {|pd[7:0], pd} & {257{cb != 0}}, "pending");
      chk(q_ct, {exp_word(4'ha), exp_word(4'h9), exp_word(4'h8)} & {192{cb != 0}}, "counts");
      chk(q_en, cb != 0, "enabled");
    end
    finish_test;
  end
endmodule // tb_pss_save_area
